// file: smsw_sleep_wake.v
// Purpose: sleep/wake mode control of a multi-input switch monitor
// Assumes: sleep and status commands arrive as decoded one-cycle strobes
// Notes: wake line is open drain; the testbench resolves the wire level
// Operation
// - sleep command enters Sleep on the chip-select rising edge ending the transfer.
// - entering Sleep releases the wake line high, disabling the supply.
// - in Normal the wake line is held low, supply enabled.
// - in Sleep a switch change, closure or opening, pulls wake low and returns to Normal.
// - wake line pulled low by another device wakes a sleeping device.
// - chip-select falling edge wakes the device into Normal.
// - switch change after the sleep command, before the chip-select rising edge, cancels the sleep entry.
// - status command wakes the device; its first data may be invalid.
// - power-on reset restores Normal mode and default register values.
// - wake source flag stays readable after wake-up.
`timescale 1ns/10ps
`include "smsw_map.vh"
module smsw_sleep_wake #(
	parameter SW_W = 22
) (
	// clock and reset
	input wire clock_in,
	input wire rstn_in,
	// spi side
	input wire cs_n_in,
	input wire sleep_cmd_in,
	input wire status_cmd_in,
	// switch comparators
	input wire [SW_W-1:0] switch_state_in,
	// shared wake line
	input wire wake_n_in,
	output reg wake_n_out,
	output reg wake_n_oe_n_out,
	// status
	output reg sleep_out,
	output reg status_invalid_out,
	output reg [`SMSW_SRC_W-1:0] wake_src_out,
	input wire wake_src_clr_in
);
	localparam ST_NORMAL = 2'b01;
	localparam ST_SLEEP = 2'b10;

	// two-stage synchronisers for pins
	reg [SW_W-1:0] sw_s1_r;
	reg [SW_W-1:0] sw_s2_r;
	reg [SW_W-1:0] sw_prev_r;
	reg cs_s1_r;
	reg cs_s2_r;
	reg cs_prev_r;
	reg wk_s1_r;
	reg wk_s2_r;
	// mode state and its pending and flag bits
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg sleep_pend_r;
	reg sleep_pend_nxt;
	reg invalid_r;
	reg invalid_nxt;
	reg [`SMSW_SRC_W-1:0] src_r;
	reg [`SMSW_SRC_W-1:0] src_nxt;
	// our own release needs two sync stages before the line reads true
	reg [1:0] settle_r;
	reg [1:0] settle_nxt;

	wire cs_rise;
	wire cs_fall;
	wire sw_change;
	wire sw_cancel;
	wire line_ready;
	wire wk_low;

	assign cs_rise = cs_s2_r & ~cs_prev_r;
	assign cs_fall = ~cs_s2_r & cs_prev_r;
	assign sw_change = |(sw_s2_r ^ sw_prev_r);
	assign sw_cancel = sw_change & ~cs_s2_r;
	assign line_ready = (settle_r == `SMSW_LINE_SETTLE);
	// without the settle mask our own stale low drive would wake us at once
	assign wk_low = ~wk_s2_r & line_ready;

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sw_s1_r <= {SW_W{1'b0}};
			sw_s2_r <= {SW_W{1'b0}};
			sw_prev_r <= {SW_W{1'b0}};
		end else begin
			sw_s1_r <= switch_state_in;
			sw_s2_r <= sw_s1_r;
			sw_prev_r <= sw_s2_r;
		end
	end

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_prev_r <= 1'b1;
		end else begin
			cs_s1_r <= cs_n_in;
			cs_s2_r <= cs_s1_r;
			cs_prev_r <= cs_s2_r;
		end
	end

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wk_s1_r <= 1'b0;
			wk_s2_r <= 1'b0;
		end else begin
			wk_s1_r <= wake_n_in;
			wk_s2_r <= wk_s1_r;
		end
	end

	always @* begin
		settle_nxt = 2'h0;
		if (state_r == ST_SLEEP) begin
			if (line_ready) begin
				settle_nxt = settle_r;
			end else begin
				settle_nxt = settle_r + 2'h1;
			end
		end
	end

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			settle_r <= 2'h0;
		end else begin
			settle_r <= settle_nxt;
		end
	end

	always @* begin
		state_nxt = state_r;
		sleep_pend_nxt = sleep_pend_r;
		invalid_nxt = invalid_r;
		src_nxt = src_r;
		if (wake_src_clr_in) begin
			src_nxt = `SMSW_SRC_NONE;
		end
		case (state_r)
		ST_NORMAL: begin
			if (sleep_cmd_in) begin
				sleep_pend_nxt = 1'b1;
			end
			if (sw_cancel) begin
				sleep_pend_nxt = 1'b0;
			end
			if (cs_rise && sleep_pend_r && !sw_cancel) begin
				state_nxt = ST_SLEEP;
				sleep_pend_nxt = 1'b0;
			end else if (cs_rise) begin
				sleep_pend_nxt = 1'b0;
			end
			// second status command yields valid data
			if (status_cmd_in && invalid_r) begin
				invalid_nxt = 1'b0;
			end
		end
		ST_SLEEP: begin
			// set wins over a same-cycle clear of the source flag
			if (sw_change) begin
				state_nxt = ST_NORMAL;
				src_nxt = `SMSW_SRC_SWITCH;
			end else if (wk_low) begin
				state_nxt = ST_NORMAL;
				src_nxt = `SMSW_SRC_WAKE_LINE;
			end else if (cs_fall || status_cmd_in) begin
				state_nxt = ST_NORMAL;
				src_nxt = `SMSW_SRC_CS;
				invalid_nxt = 1'b1;
			end
		end
		default: begin
			state_nxt = ST_NORMAL;
			sleep_pend_nxt = 1'b0;
		end
		endcase
	end

	// async reset models the internal power-on monitor
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= ST_NORMAL;
			sleep_pend_r <= 1'b0;
			invalid_r <= 1'b0;
			src_r <= `SMSW_SRC_NONE;
			wake_n_out <= 1'b0;
			wake_n_oe_n_out <= 1'b0;
			sleep_out <= 1'b0;
			status_invalid_out <= 1'b0;
			wake_src_out <= `SMSW_SRC_NONE;
		end else begin
			state_r <= state_nxt;
			sleep_pend_r <= sleep_pend_nxt;
			invalid_r <= invalid_nxt;
			src_r <= src_nxt;
			// drive low in Normal, release in Sleep for the pull-up
			wake_n_out <= 1'b0;
			wake_n_oe_n_out <= (state_nxt == ST_SLEEP);
			sleep_out <= (state_nxt == ST_SLEEP);
			status_invalid_out <= invalid_nxt;
			wake_src_out <= src_nxt;
		end
	end
endmodule

// file: smsw_map.vh
// Purpose: constants for the sleep/wake controller
// Assumes: one 250 MHz clock, active-low async reset
// Notes: wake source codes are reported on a status output
`ifndef SMSW_MAP_VH
`define SMSW_MAP_VH
`define SMSW_CLK_PERIOD_NS 4
`define SMSW_SRC_W 3
`define SMSW_SRC_NONE 3'h0
`define SMSW_SRC_SWITCH 3'h1
`define SMSW_SRC_WAKE_LINE 3'h2
`define SMSW_SRC_CS 3'h4
`define SMSW_LINE_SETTLE 2'h2
`endif

// file: smsw_supply.sv
// Purpose: shared wake line and supply enable. Assumes: pull-up on the wire. Notes: peer models a second device
`timescale 1ns/10ps
module smsw_supply (input wire oe_n_in, input wire peer_n_in, output wire wake_n_out);
	// released line reads high from the pull-up, never a held value
	assign wake_n_out = oe_n_in & peer_n_in;
endmodule

// file: smsw_checker.sv
// Purpose: sleep/wake port checks. Assumes: one clock. Notes: windows cover input sync delay
`timescale 1ns/10ps
module smsw_checker #(parameter SW_W = 22) (input wire clock_in, input wire rstn_in, input wire cs_n_in,
	input wire sleep_cmd_in, input wire status_cmd_in, input wire [SW_W-1:0] switch_state_in,
	input wire wake_n_in, input wire wake_n_out, input wire wake_n_oe_n_out, input wire sleep_out,
	input wire status_invalid_out, input wire [2:0] wake_src_out, input wire wake_src_clr_in);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	oe_follow_a: assert property (wake_n_oe_n_out == sleep_out) else $error("oe");
	drive_low_a: assert property (!wake_n_out) else $error("drive");
	switch_wake_a: assert property (sleep_out && $changed(switch_state_in) |-> ##[1:5] !sleep_out)
		else $error("switch");
	line_wake_a: assert property (sleep_out && !wake_n_in |-> ##[1:5] !sleep_out) else $error("line");
	cs_wake_a: assert property (sleep_out && $fell(cs_n_in) |-> ##[1:5] !sleep_out) else $error("cs");
	sleep_cancel_a: assert property (!sleep_out && !cs_n_in && $changed(switch_state_in) |-> !sleep_out [*6])
		else $error("cancel");
	status_wake_a: assert property (sleep_out && status_cmd_in |-> ##[1:5] (!sleep_out && status_invalid_out))
		else $error("status");
	wake_source_a: assert property ($fell(sleep_out) |-> wake_src_out != 3'h0) else $error("src");
endmodule
bind smsw_sleep_wake smsw_checker #(.SW_W(SW_W)) chk(.*);

// file: tb_top.sv
// Purpose: sleep/wake bench. Assumes: 4 ns clock. Notes: sleep_out changes are matched against a queue
`timescale 1ns/10ps
module tb_top;
	reg clock_in = 0, rstn_in = 0, cs_n_in = 1, sleep_cmd_in = 0, status_cmd_in = 0, wake_src_clr_in = 0, peer = 1;
	reg [21:0] switch_state_in = 0;
	reg [2:0] q[$];
	reg last = 0;
	integer fail_count = 0, checked = 0, k;
	wire wake_n_in, wake_n_out, wake_n_oe_n_out, sleep_out, status_invalid_out;
	wire [2:0] wake_src_out;
	smsw_sleep_wake dut(.*);
	// peer is a parallel device on the shared line that wakes at its own time
	smsw_supply psu(.oe_n_in(wake_n_oe_n_out), .peer_n_in(peer), .wake_n_out(wake_n_in));
	// one device only: a chained frame of 48 clocks is outside this block
	// no registers here, so periodic rewrites have nothing to restore
	initial forever #2 clock_in = ~clock_in;
	task tick(input integer n); begin repeat (n) @(posedge clock_in); #1; end endtask
	task cmp(input [2:0] e, input [2:0] g); begin
		checked = checked + 1;
		if (g !== e) begin fail_count = fail_count + 1; $display("FAIL %0t got %h want %h", $time, g, e); end
	end endtask
	task close_out; begin
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	end endtask
	// a switch change after the command must cancel the pending entry
	task go_sleep(input x); begin
		cs_n_in = 0; tick(2); sleep_cmd_in = 1; tick(1); sleep_cmd_in = 0;
		if (x) switch_state_in[$urandom % 22] ^= 1'b1;
		tick(2); cs_n_in = 1;
		if (!x) q.push_back(3'h1);
		tick(10);
	end endtask
	always @(posedge clock_in) if (rstn_in && sleep_out !== last) begin
		last = sleep_out;
		cmp(q.size() ? q.pop_front() : 3'h7, {2'h0, sleep_out});
	end
	initial begin
		k = $urandom(39463);
		tick(5); rstn_in = 1;
		cmp(3'h0, {status_invalid_out, wake_n_oe_n_out, sleep_out});
		tick(3);
		// switches are left settled and acknowledged before each sleep command
		for (k = 0; k < 4; k = k + 1) begin
			go_sleep(0);
			cmp(3'h3, {1'b0, wake_n_oe_n_out, wake_n_in});
			if (k == 0) switch_state_in[$urandom % 22] ^= 1'b1;
			if (k == 1) peer = 0;
			if (k == 2) cs_n_in = 0;
			if (k == 3) status_cmd_in = 1;
			q.push_back(3'h0);
			tick(1); status_cmd_in = 0; tick(8); peer = 1; cs_n_in = 1;
			cmp(k == 0 ? 3'h1 : k == 1 ? 3'h2 : 3'h4, wake_src_out);
			if (k == 3) cmp(3'h1, {2'h0, status_invalid_out});
			wake_src_clr_in = 1; tick(1); wake_src_clr_in = 0; tick(4);
			$display("test %0d done", k);
		end
		go_sleep(1); cmp(3'h0, {2'h0, sleep_out});
		// settle wait between the two status commands, scaled down to cycles
		status_cmd_in = 1; tick(1); status_cmd_in = 0; tick(4);
		cmp(3'h0, {2'h0, status_invalid_out});
		$display("cancel and status done");
		close_out;
	end
	initial begin #5000; fail_count = fail_count + 1; close_out; end
endmodule
